// >>> rtl/pvs_pkg.sv
package pvs_pkg;
  localparam int unsigned SYS_HZ = 200_000_000;
  localparam int unsigned FRAME_HZ = 8000;
  localparam int unsigned RATE_128_HZ = 128_000;
  localparam int unsigned RATE_256_HZ = 256_000;
  localparam int unsigned RATE_512_HZ = 512_000;

  // half bit clock periods in system cycles, rounded down
  localparam logic [9:0] HALF_128 = 10'(SYS_HZ / (2 * RATE_128_HZ));
  localparam logic [9:0] HALF_256 = 10'(SYS_HZ / (2 * RATE_256_HZ));
  localparam logic [9:0] HALF_512 = 10'(SYS_HZ / (2 * RATE_512_HZ));
  // bit clocks per 8 kHz frame
  localparam logic [6:0] BPF_128 = 7'(RATE_128_HZ / FRAME_HZ);
  localparam logic [6:0] BPF_256 = 7'(RATE_256_HZ / FRAME_HZ);
  localparam logic [6:0] BPF_512 = 7'(RATE_512_HZ / FRAME_HZ);

  localparam logic [6:0] LONG_SYNC_BITS = 7'h08;
  localparam logic [3:0] SLOT_LAST_16 = 4'hF;
  localparam logic [3:0] SLOT_LAST_8 = 4'h7;
  localparam logic [1:0] SLOT_LAST_IDX = 2'h3;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SLOTS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TX0 = 8'h10;
  localparam logic [7:0] ADDR_RX0 = 8'h20;
  localparam int CFG_W = 18;
  localparam logic [CFG_W-1:0] CTRL_RST = 18'h00000;
  localparam logic [3:0] SLOTS_RST = 4'h1;

  typedef enum logic [1:0] {
    PVS_FMT_LONG = 2'b00,
    PVS_FMT_SHORT = 2'b01,
    PVS_FMT_GCI = 2'b10
  } pvs_frame_t;

  typedef enum logic [1:0] {
    PVS_SMP_8 = 2'b00,
    PVS_SMP_13 = 2'b01,
    PVS_SMP_16 = 2'b10
  } pvs_sample_t;

  typedef enum logic [1:0] {
    PVS_PAD_SIGN = 2'b00,
    PVS_PAD_ZERO = 2'b01,
    PVS_PAD_ATTEN = 2'b10
  } pvs_pad_t;

  typedef enum logic [1:0] {
    PVS_RATE_128 = 2'b00,
    PVS_RATE_256 = 2'b01,
    PVS_RATE_512 = 2'b10
  } pvs_rate_t;

  // control register layout, msb first: bit 17 enable .. bit 0 hiz_early
  typedef struct packed {
    logic enable;
    logic master;
    pvs_frame_t frame;
    pvs_rate_t rate;
    logic slot16;
    pvs_sample_t sample;
    logic big_endian;
    pvs_pad_t pad;
    logic [2:0] atten;
    logic mute;
    logic sync_off;
    logic hiz_early;
  } pvs_cfg_t;

  typedef struct packed {
    logic clk;
    logic sync;
    logic din;
  } pvs_pins_t;
endpackage

// >>> rtl/pvs_sync.sv
`timescale 1ns/1ps
module pvs_sync #(
  parameter int W = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a bit moves only once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      o_q <= (o_q & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
    end
  end
endmodule

// >>> rtl/pvs_port.sv
`timescale 1ns/1ps
// What this block does
// [R1] master drives bit clock and frame sync at 128, 256 or 512 kHz
// [R2] slave takes bit clock and sync from outside, bit clock up to 2048 kHz
// [R3] samples are 13/16-bit linear or 8-bit companded, one per slot per 8 kHz frame
// [R4] up to three of the first four slots carry data, one channel each
// [R5] long frame sync: rising sync edge marks the sample word start
// [R6] master in long frame sync holds sync high eight bit clocks
// [R7] slave long sync: far end holds sync two falls to 62.5 us
// [R8] input sampled on falling clock edges, output launched on rising edges
// [R9] output released after slot last bit, on its fall or next rise
// [R10] short frame sync: one clock high, falling edge marks word start
// [R11] gci: each bit spans two clocks, samples are 8-bit companded
// [R12] gci: sync pulse starts each 8 kHz frame, channels in first four slots
// [R13] slots are 8 or 16 clocks; 8-clock slots only for 8-bit samples; in gci the code uses 8-clock slots for any sample setting
// [R14] bit order in slot selectable, little or big endian
// [R15] unused bits of 16-clock slots: sign, zeros or 3-bit attenuation
// [R16] mute drives every output data bit as zero
// [R17] master can hold sync low while bit clock keeps running
// [R18] first slot starts the period after frame start, slots back to back
module pvs_port
  import pvs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  input wire logic i_pcm_clk,
  output logic o_pcm_clk,
  output logic o_pcm_clk_oe_n,
  input wire logic i_pcm_sync,
  output logic o_pcm_sync,
  output logic o_pcm_sync_oe_n,
  input wire logic i_pcm_in,
  output logic o_pcm_out,
  output logic o_pcm_out_oe_n
);
  pvs_cfg_t cfg;
  logic [3:0] slot_en;
  logic [15:0] tx_data [4];
  logic [15:0] rx_data [4];
  logic [3:0] rx_new;
  logic [7:0] frame_cnt;
  logic [9:0] div_cnt;
  logic [9:0] half;
  logic [6:0] bpf;
  logic mclk;
  logic [6:0] mbit;
  logic [6:0] next_mbit;
  logic sync_r;
  logic next_sync;
  pvs_pins_t pins_s;
  logic s_clk_q;
  logic is_master;
  logic m_rise;
  logic m_fall;
  logic rise_ev;
  logic fall_ev;
  logic sync_lvl;
  logic sync_q;
  logic start_pend;
  logic start_now;
  logic gci;
  logic gphase;
  logic active;
  logic [1:0] slot;
  logic [3:0] bitc;
  logic eff16;
  logic last_bit;
  logic advance;
  logic bit_fall;
  logic next_active;
  logic [1:0] next_slot;
  logic [3:0] next_bitc;
  logic [15:0] tx_word;
  logic [15:0] rx_acc;
  logic [15:0] next_acc;
  logic [3:0] rx_idx;
  logic [3:0] tx_idx;
  logic [3:0] rd_clr;
  logic [31:0] rd_val;

  assign is_master = cfg.enable && cfg.master;
  assign gci = (cfg.frame == PVS_FMT_GCI);
  assign eff16 = !gci && (cfg.slot16 || (cfg.sample != PVS_SMP_8));  // [R11] [R13]
  assign last_bit = (bitc == (eff16 ? SLOT_LAST_16 : SLOT_LAST_8));

  // ---------------- register port ----------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg <= pvs_cfg_t'(CTRL_RST);
      slot_en <= SLOTS_RST;
      for (int i = 0; i < 4; i++) begin
        tx_data[i] <= 16'h0000;
      end
    end else if (i_ce && i_we) begin
      if (i_addr == ADDR_CTRL) begin
        cfg <= pvs_cfg_t'(i_wdata[CFG_W-1:0]);
      end
      if (i_addr == ADDR_SLOTS) begin
        // a fourth channel is dropped, only three fit
        slot_en <= (i_wdata[3:0] == 4'hF) ? 4'h7 : i_wdata[3:0];  // [R4]
      end
      for (int i = 0; i < 4; i++) begin
        if (i_addr == ADDR_TX0 + 8'(4 * i)) begin
          tx_data[i] <= i_wdata[15:0];
        end
      end
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_clr = 4'h0;
    if (i_addr == ADDR_CTRL) begin
      rd_val = {14'h0000, cfg};
    end else if (i_addr == ADDR_SLOTS) begin
      rd_val = {28'h0000000, slot_en};
    end else if (i_addr == ADDR_STATUS) begin
      rd_val = {16'h0000, frame_cnt, 3'h0, active, rx_new};
    end
    for (int i = 0; i < 4; i++) begin
      if (i_addr == ADDR_TX0 + 8'(4 * i)) begin
        rd_val = {16'h0000, tx_data[i]};
      end
      if (i_addr == ADDR_RX0 + 8'(4 * i)) begin
        rd_val = {16'h0000, rx_data[i]};
        rd_clr[i] = i_re;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_rdata <= i_re ? rd_val : 32'h00000000;
    end
  end

  // ---------------- master clock and sync ----------------
  always_comb begin
    unique case (cfg.rate)
      PVS_RATE_256: begin
        half = HALF_256;
        bpf = BPF_256;
      end
      PVS_RATE_512: begin
        half = HALF_512;
        bpf = BPF_512;
      end
      default: begin
        half = HALF_128;
        bpf = BPF_128;
      end
    endcase
  end

  assign m_rise = is_master && (div_cnt == half - 10'h001) && !mclk;
  assign m_fall = is_master && (div_cnt == half - 10'h001) && mclk;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt <= 10'h000;
      mclk <= 1'b0;
    end else if (i_ce) begin
      if (!is_master) begin
        div_cnt <= 10'h000;
        mclk <= 1'b0;
      end else if (div_cnt == half - 10'h001) begin
        div_cnt <= 10'h000;
        mclk <= ~mclk;  // [R1]
      end else begin
        div_cnt <= div_cnt + 10'h001;
      end
    end
  end

  always_comb begin
    next_mbit = (mbit >= bpf - 7'h01) ? 7'h00 : mbit + 7'h01;
    if (cfg.sync_off) begin
      next_sync = 1'b0;  // [R17]
    end else if (cfg.frame == PVS_FMT_LONG) begin
      next_sync = (next_mbit < LONG_SYNC_BITS);  // [R6]
    end else begin
      next_sync = (next_mbit == 7'h00);  // [R10] [R12]
    end
  end

  // sync moves on the rising clock edge, or at once when sync_off is set, one pulse per 8 kHz frame
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mbit <= 7'h7F;
      sync_r <= 1'b0;
    end else if (i_ce) begin
      if (!is_master) begin
        mbit <= 7'h7F;
        sync_r <= 1'b0;
      end else if (m_rise || cfg.sync_off) begin
        mbit <= m_rise ? next_mbit : mbit;
        sync_r <= next_sync;  // [R17] a pulse in flight is cut at once
      end
    end
  end

  assign o_pcm_clk = mclk;
  assign o_pcm_sync = sync_r;
  assign o_pcm_clk_oe_n = ~is_master;  // [R1]
  assign o_pcm_sync_oe_n = ~is_master;

  // ---------------- slave pins ----------------
  // three-stage filter bounds slave clock to well under SYS_HZ / 4
  pvs_sync #(
    .W(3)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_d({i_pcm_clk, i_pcm_sync, i_pcm_in}),
    .o_q(pins_s)
  );

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_clk_q <= 1'b0;
    end else if (i_ce) begin
      s_clk_q <= pins_s.clk;
    end
  end

  // [R2]
  assign rise_ev = is_master ? m_rise : (cfg.enable && pins_s.clk && !s_clk_q);
  assign fall_ev = is_master ? m_fall : (cfg.enable && !pins_s.clk && s_clk_q);
  assign sync_lvl = is_master ? sync_r : pins_s.sync;

  // ---------------- frame engine ----------------
  // only the sync edge counts, so any legal long sync width works  [R7]
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_q <= 1'b0;
      start_pend <= 1'b0;
    end else if (i_ce) begin
      if (!cfg.enable) begin
        sync_q <= 1'b0;
        start_pend <= 1'b0;
      end else if (fall_ev) begin
        sync_q <= sync_lvl;
        if (cfg.frame == PVS_FMT_LONG) begin
          start_pend <= sync_lvl && !sync_q;  // [R5]
        end else begin
          start_pend <= !sync_lvl && sync_q;  // [R10] [R12]
        end
      end else if (rise_ev) begin
        start_pend <= 1'b0;
      end
    end
  end

  assign start_now = rise_ev && start_pend;
  // in gci the second clock of a bit neither launches nor advances  [R11]
  assign advance = rise_ev && !start_pend && active && (!gci || !gphase);
  assign bit_fall = fall_ev && active && (!gci || !gphase);

  always_comb begin
    next_active = active;
    next_slot = slot;
    next_bitc = bitc;
    if (start_now) begin
      next_active = 1'b1;  // [R18]
      next_slot = 2'h0;
      next_bitc = 4'h0;
    end else if (advance) begin
      if (!last_bit) begin
        next_bitc = bitc + 4'h1;
      end else begin
        next_bitc = 4'h0;
        next_slot = slot + 2'h1;  // [R18]
        next_active = (slot != SLOT_LAST_IDX);  // [R4]
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active <= 1'b0;
      slot <= 2'h0;
      bitc <= 4'h0;
      gphase <= 1'b0;
      frame_cnt <= 8'h00;
    end else if (i_ce) begin
      if (!cfg.enable) begin
        active <= 1'b0;
        gphase <= 1'b0;
      end else begin
        active <= next_active;
        slot <= next_slot;
        bitc <= next_bitc;
        if (start_now) begin
          gphase <= gci;
          frame_cnt <= frame_cnt + 8'h01;
        end else if (rise_ev && gci) begin
          gphase <= ~gphase;  // [R11]
        end
      end
    end
  end

  // ---------------- slot word and bit order ----------------
  always_comb begin
    unique case (cfg.sample)
      PVS_SMP_13: begin
        unique case (cfg.pad)
          PVS_PAD_SIGN: tx_word = {tx_data[next_slot][12:0], {3{tx_data[next_slot][12]}}};
          PVS_PAD_ATTEN: tx_word = {tx_data[next_slot][12:0], cfg.atten};
          default: tx_word = {tx_data[next_slot][12:0], 3'h0};
        endcase  // [R15]
      end
      PVS_SMP_16: tx_word = tx_data[next_slot];  // [R3]
      default: begin
        unique case (cfg.pad)
          PVS_PAD_SIGN: tx_word = {tx_data[next_slot][7:0], {8{tx_data[next_slot][7]}}};
          PVS_PAD_ATTEN: tx_word = {tx_data[next_slot][7:0], 5'h00, cfg.atten};
          default: tx_word = {tx_data[next_slot][7:0], 8'h00};
        endcase  // [R15]
      end
    endcase
    // 8-clock slots use only the upper byte of the word
    tx_idx = cfg.big_endian ? 4'hF - next_bitc : (eff16 ? next_bitc : 4'h8 + next_bitc);  // [R14]
    rx_idx = cfg.big_endian ? 4'hF - bitc : (eff16 ? bitc : 4'h8 + bitc);  // [R14]
    next_acc = rx_acc;
    next_acc[rx_idx] = pins_s.din;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pcm_out <= 1'b0;
      o_pcm_out_oe_n <= 1'b1;
    end else if (i_ce) begin
      if (!cfg.enable) begin
        o_pcm_out <= 1'b0;
        o_pcm_out_oe_n <= 1'b1;
      end else if (start_now || advance) begin
        if (next_active && slot_en[next_slot]) begin
          o_pcm_out <= cfg.mute ? 1'b0 : tx_word[tx_idx];  // [R8] [R16]
          o_pcm_out_oe_n <= 1'b0;
        end else begin
          o_pcm_out <= 1'b0;
          o_pcm_out_oe_n <= 1'b1;  // [R9]
        end
      end else if (bit_fall && last_bit && cfg.hiz_early) begin
        o_pcm_out_oe_n <= 1'b1;  // [R9]
      end
    end
  end

  // capture on the falling edge; companded bytes pass through untouched
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_acc <= 16'h0000;
      rx_new <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        rx_data[i] <= 16'h0000;
      end
    end else if (i_ce) begin
      if (bit_fall && slot_en[slot]) begin
        rx_acc <= next_acc;  // [R8]
      end
      for (int i = 0; i < 4; i++) begin
        // a fresh sample wins over a read in the same cycle
        if (bit_fall && last_bit && slot_en[slot] && slot == 2'(i)) begin
          unique case (cfg.sample)
            PVS_SMP_13: rx_data[i] <= {3'h0, next_acc[15:3]};
            PVS_SMP_16: rx_data[i] <= next_acc;
            default: rx_data[i] <= {8'h00, next_acc[15:8]};
          endcase  // [R3]
          rx_new[i] <= 1'b1;
        end else if (rd_clr[i]) begin
          rx_new[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------- assertions ----------------
  logic [3:0] sync_hi_cnt;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_hi_cnt <= 4'h0;
    end else if (i_ce && m_rise) begin
      sync_hi_cnt <= sync_r ? sync_hi_cnt + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  sequence sync_fall_s;
    is_master && !cfg.sync_off && $fell(sync_r);
  endsequence

  long_sync_len_a: assert property ( // [R6]
    sync_fall_s and (cfg.frame == PVS_FMT_LONG) |-> sync_hi_cnt == 4'h8)
    else $error("long sync not eight bit clocks");
  short_sync_len_a: assert property ( // [R10]
    sync_fall_s and (cfg.frame == PVS_FMT_SHORT) |-> sync_hi_cnt == 4'h1)
    else $error("short sync not one bit clock");
  master_clk_drive_a: assert property ( // [R1]
    is_master |-> !o_pcm_clk_oe_n && !o_pcm_sync_oe_n)
    else $error("master not driving clock and sync");
  sync_forced_low_a: assert property ( // [R17]
    is_master && cfg.sync_off && $past(cfg.sync_off) && $past(is_master) |-> !o_pcm_sync)
    else $error("sync not held low");
  mute_zero_a: assert property ( // [R16]
    i_ce && cfg.enable && cfg.mute && (start_now || advance) |=> !o_pcm_out)
    else $error("muted output not zero");
  out_on_rise_a: assert property ( // [R8]
    $changed(o_pcm_out) |-> $past(rise_ev && i_ce) || $past(!cfg.enable))
    else $error("output changed off a rising edge");
  early_release_a: assert property ( // [R9]
    i_ce && bit_fall && last_bit && cfg.hiz_early && cfg.enable |=> o_pcm_out_oe_n)
    else $error("output not released on last bit fall");
  slot_len_a: assert property ( // [R13]
    active && bitc > 4'h7 |-> eff16)
    else $error("bit count past 8-clock slot");
endmodule

// >>> verification/pvs_codec_model.sv
`timescale 1ns/1ps
module pvs_codec_model (
  input wire logic i_gen,
  input wire logic i_long,
  input wire logic i_clk,
  input wire logic i_sync,
  input wire logic i_out,
  input wire logic i_out_oe_n,
  output logic o_clk,
  output logic o_sync,
  output logic o_din,
  output logic [15:0] o_rx,
  output logic [7:0] o_frames
);
  localparam logic [15:0] WORD = 16'hC3A5;
  logic [5:0] bc;
  logic [4:0] idx;
  logic prev;
  logic last;

  initial begin
    o_clk = 1'b0;
    o_sync = 1'b0;
    o_din = 1'b0;
    o_rx = 16'h0000;
    o_frames = 8'h00;
    bc = 6'h00;
    idx = 5'h10;
    prev = 1'b0;
    last = 1'b0;
  end

  // offset keeps link edges away from system edges; clock stands still when idle
  initial begin
    #0.7;
    forever begin
      #62.5;
      o_clk = i_gen ? ~o_clk : 1'b0;
    end
  end

  // 64 clocks a frame so all four slots fit
  always @(posedge o_clk) begin
    bc <= bc + 6'h01;
    o_sync <= i_long ? (bc < 6'h08) : (bc == 6'h00);
  end

  // released line reads as the inverse of the last driven value
  always @(i_out or i_out_oe_n) begin
    if (!i_out_oe_n) begin
      last = i_out;
    end
  end

  always @(negedge i_clk) begin
    prev <= i_sync;
    if (i_long ? (!prev && i_sync) : (prev && !i_sync)) begin
      idx <= 5'h00;
    end else if (idx < 5'h10) begin
      o_rx <= {o_rx[14:0], i_out_oe_n ? ~last : i_out};
      idx <= idx + 5'h01;
      if (idx == 5'h0F) begin
        o_frames <= o_frames + 8'h01;
      end
    end
  end

  always @(posedge i_clk) begin
    o_din <= (idx < 5'h10) ? WORD[4'hF - idx[3:0]] : ~o_din;
  end
endmodule

// >>> verification/pvs_port_tb.sv
`timescale 1ns/1ps
module pcm_voice_serial_port_tb_top
  import pvs_pkg::*;
;
  typedef struct packed {
    pvs_frame_t f;
    pvs_sample_t s;
    logic big;
    pvs_pad_t p;
    logic mute;
    logic hiz;
    logic [15:0] ex_out;
    logic [15:0] ex_rx;
  } pvs_case_t;
  // device sends B2E7 (atten 5), codec sends C3A5
  localparam pvs_case_t CASES [7] = '{
    '{PVS_FMT_SHORT, PVS_SMP_16, 1'b1, PVS_PAD_SIGN, 1'b0, 1'b0, 16'hB2E7, 16'hC3A5},
    '{PVS_FMT_SHORT, PVS_SMP_16, 1'b0, PVS_PAD_SIGN, 1'b0, 1'b1, 16'hE74D, 16'hA5C3},
    '{PVS_FMT_LONG, PVS_SMP_8, 1'b1, PVS_PAD_ZERO, 1'b0, 1'b0, 16'hE700, 16'h00C3},
    '{PVS_FMT_LONG, PVS_SMP_8, 1'b1, PVS_PAD_SIGN, 1'b0, 1'b1, 16'hE7FF, 16'h00C3},
    '{PVS_FMT_SHORT, PVS_SMP_13, 1'b1, PVS_PAD_ATTEN, 1'b0, 1'b0, 16'h973D, 16'h1874},
    '{PVS_FMT_LONG, PVS_SMP_16, 1'b1, PVS_PAD_SIGN, 1'b1, 1'b0, 16'h0000, 16'hC3A5},
    '{PVS_FMT_GCI, PVS_SMP_8, 1'b1, PVS_PAD_ZERO, 1'b0, 1'b0, 16'hFC3F, 16'h0000}
  };
  logic clk = 1'b0;
  logic arst_n, ce, we, re, gen, long_fs;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic d_clk, d_clk_oe_n, d_sync, d_sync_oe_n, d_out, d_out_oe_n;
  logic m_clk, m_sync, m_din, pcm_clk, pcm_sync;
  logic [15:0] rxw;
  logic [7:0] frames;
  pvs_cfg_t c;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int bits = 0;
  int shi = 0;
  int b0, s0;

  always #2.5 clk = ~clk;
  assign pcm_clk = d_clk_oe_n ? m_clk : d_clk;
  assign pcm_sync = d_sync_oe_n ? m_sync : d_sync;

  pvs_port DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .i_pcm_clk(pcm_clk),
    .o_pcm_clk(d_clk), .o_pcm_clk_oe_n(d_clk_oe_n), .i_pcm_sync(pcm_sync),
    .o_pcm_sync(d_sync), .o_pcm_sync_oe_n(d_sync_oe_n), .i_pcm_in(m_din),
    .o_pcm_out(d_out), .o_pcm_out_oe_n(d_out_oe_n));
  pvs_codec_model u_codec (.i_gen(gen), .i_long(long_fs), .i_clk(pcm_clk),
    .i_sync(pcm_sync), .i_out(d_out), .i_out_oe_n(d_out_oe_n), .o_clk(m_clk),
    .o_sync(m_sync), .o_din(m_din), .o_rx(rxw), .o_frames(frames));

  // sync is stable at falls, so count there
  always @(negedge pcm_clk) begin
    bits++;
    if (pcm_sync) begin
      shi++;
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic wait_frame;
    logic [7:0] f0;
    f0 = frames;
    for (int n = 0; n < 30000 && frames === f0; n++) begin
      @(posedge clk);
    end
    if (frames === f0) begin
      miscompares++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 98000) begin
      miscompares++;
      finish_test;
    end
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    we = 1'b0;
    re = 1'b0;
    gen = 1'b0;
    long_fs = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL);
    check(got, {14'h0, CTRL_RST});
    rd(ADDR_SLOTS);
    check(got, 32'h1);
    rd(ADDR_STATUS);
    check(got, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    check(got, 32'h0);
    wr(ADDR_SLOTS, 32'hF);
    rd(ADDR_SLOTS);
    check(got, 32'h7);
    wr(ADDR_SLOTS, 32'h1);
    wr(ADDR_TX0, 32'h0000B2E7);
    gen <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      c = '0;
      c.enable = 1'b1;
      c.slot16 = 1'b1;
      c.atten = 3'h5;
      c.frame = CASES[i].f;
      c.sample = CASES[i].s;
      c.big_endian = CASES[i].big;
      c.pad = CASES[i].p;
      c.mute = CASES[i].mute;
      c.hiz_early = CASES[i].hiz;
      long_fs <= (CASES[i].f == PVS_FMT_LONG);
      wr(ADDR_CTRL, {14'h0, c});
      // first frame may straddle the change of format
      wait_frame;
      wait_frame;
      check({16'h0, rxw}, {16'h0, CASES[i].ex_out});
      if (CASES[i].f != PVS_FMT_GCI) begin
        rd(ADDR_RX0);
        check(got, {16'h0, CASES[i].ex_rx});
      end
      repeat (2) @(negedge pcm_clk);
      check({31'h0, d_out_oe_n}, 32'h1);
    end
    gen <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    long_fs <= 1'b1;
    c = '0;
    c.enable = 1'b1;
    c.master = 1'b1;
    c.frame = PVS_FMT_LONG;
    c.rate = PVS_RATE_512;
    c.sample = PVS_SMP_8;
    c.big_endian = 1'b1;
    wr(ADDR_CTRL, {14'h0, c});
    wait_frame;
    b0 = bits;
    s0 = shi;
    check({24'h0, rxw[15:8]}, 32'hE7);
    rd(ADDR_RX0);
    check(got, 32'hC3);
    wait_frame;
    check(32'(bits - b0), 32'h40);
    check(32'(shi - s0), 32'h8);
    c.sync_off = 1'b1;
    wr(ADDR_CTRL, {14'h0, c});
    b0 = bits;
    s0 = shi;
    repeat (20000) @(posedge clk);
    check(32'(shi - s0), 32'h0);
    check({31'h0, (bits - b0) > 40}, 32'h1);
    finish_test;
  end
endmodule
